//--- hlcs_pkg.sv
// Package for the host link control and status register bank.
// Assumes a single 25 MHz clock and an Avalon-MM slave with byte addresses.
package hlcs_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock rate and soft restart duration
  localparam int unsigned CLK_MHZ           = 25;
  localparam int unsigned RESTART_NS        = 1000;
  localparam int unsigned RESTART_CYCLES    = (RESTART_NS * CLK_MHZ + 999) / 1000;

  // Register byte offsets
  localparam logic [5:0] OFS_ROM_MAP        = 6'h00;
  localparam logic [5:0] OFS_LOG_UPPER      = 6'h04;
  localparam logic [5:0] OFS_LOG_LOWER      = 6'h08;
  localparam logic [5:0] OFS_VENDOR         = 6'h0c;
  localparam logic [5:0] OFS_CTL_SET        = 6'h10;
  localparam logic [5:0] OFS_CTL_CLR        = 6'h14;
  localparam logic [5:0] OFS_NR_BASE        = 6'h18;
  localparam logic [5:0] OFS_NR_COUNT       = 6'h1c;
  localparam logic [5:0] OFS_MC_SELECT      = 6'h20;
  localparam logic [5:0] OFS_MC_GRANT       = 6'h24;
  localparam logic [5:0] OFS_EVENTS         = 6'h28;

  // Control word bit positions
  localparam int unsigned BIT_BIG_ENDIAN    = 30;
  localparam int unsigned BIT_PHY_PROG      = 23;
  localparam int unsigned BIT_ENH_PHY       = 22;
  localparam int unsigned BIT_LINK_POWER    = 19;
  localparam int unsigned BIT_LATE_ALLOW    = 18;
  localparam int unsigned BIT_LINK_ON       = 17;
  localparam int unsigned BIT_SW_RESTART    = 16;

  // Event and node report field positions
  localparam int unsigned BIT_LATE_FAULT    = 8;
  localparam int unsigned BIT_NR_FAULT      = 31;
  localparam int unsigned POS_NR_EPOCH      = 16;
  localparam int unsigned POS_NR_LEN        = 2;

  // Alignments and internal ROM span
  localparam int unsigned ROM_ALIGN_BITS    = 10;
  localparam int unsigned NR_ALIGN_BITS     = 11;
  localparam logic [9:0]  ROM_INTERNAL_BYTES = 10'h014;

  // Reset values
  localparam logic [7:0]  RST_RESTART_CNT   = 8'(RESTART_CYCLES);
  localparam logic        RST_LINK_ON       = 1'b0;
  localparam logic        RST_LINK_POWER    = 1'b0;

  typedef enum logic [1:0] {
    HLCS_RUN     = 2'b01,
    HLCS_RESTART = 2'b10
  } hlcs_mode_e;

endpackage

//--- hlcs_regs.sv
// Host link control and status register bank with Avalon-MM slave port.
// Link side event inputs are synchronous to clock_in and one cycle wide.
// Contexts requesting multi-channel receive are driven from same-clock logic.
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.

// Operation
// RQ1: ROM mapping base keeps only address bits aligned to 1024 bytes.
// RQ2: First 20 bytes of configuration ROM come from internal storage.
// RQ3: Software writes ROM mapping base before setting link on.
// RQ4: Host bus error on late store logs source and offset, then raises flag.
// RQ5: Log captures only while late store allow is set; writing one enables.
// RQ6: Fault log is a four entry first-in first-out store.
// RQ7: Software reads upper, lower, clears flag; repeats while flag stays set.
// RQ8: Upper log word holds source node in 31:16, offset upper in 15:0, read-only.
// RQ9: Vendor word read-only: fixed extra field 31:24, organisation code 23:0.
// RQ10: Software sets byte order and late store allow only while link off.
// RQ11: Bit 30 one selects big-endian, zero selects little-endian handling.
// RQ12: Bit 23 always reads zero, bit 22 always reads one.
// RQ13: Link on clears automatically on bus disconnect.
// RQ14: Writing one to bit 19 powers the link layer; resets to zero.
// RQ15: Writing one to bit 17 enables the link; resets to zero.
// RQ16: Writing bit 16 starts soft restart; reads one during any reset.
// RQ17: Node report count bit 31 sets on node report store error.
// RQ18: Node report epoch in 23:16 increments on every bus reset.
// RQ19: Node report length in 12:2 gives quadlets, clears on bus reset.
// RQ20: Node report buffer base is aligned to 2048 bytes.
// RQ21: Multi-channel select serves one context, lowest numbered requester wins.
// RQ22: Software sets fill and header bits; match field ignored in that mode.
// RQ23: Late store fault is event bit 8, set on error after completion ack.
module hlcs_regs #(
  parameter int unsigned   LOG_DEPTH    = 4,
  parameter int unsigned   NUM_CTX      = 4,
  parameter logic [7:0]    VENDOR_EXTRA = 8'h5a,    // Arbitrary value
  parameter logic [23:0]   ORG_CODE     = 24'h3c1e07 // Arbitrary value
) (
  // Clock, reset and Avalon-MM slave
  input  wire logic          clock_in,
  input  wire logic          nrst_in,
  input  wire logic [5:0]    address_in,
  input  wire logic          read_in,
  input  wire logic          write_in,
  input  wire logic [31:0]   writedata_in,
  input  wire logic [3:0]    byteenable_in,
  output logic [31:0]        readdata_out,
  output logic               waitrequest_out,
  // Link layer status and fetch requests, same clock
  input  wire logic          late_store_err_in,
  input  wire logic [15:0]   originator_node_in,
  input  wire logic [47:0]   fault_offset_in,
  input  wire logic          bus_reset_in,
  input  wire logic          disconnect_in,
  input  wire logic          node_report_store_fault_in,
  input  wire logic          node_report_done_in,
  input  wire logic [10:0]   node_report_length_in,
  input  wire logic [9:0]    rom_fetch_offset_in,
  input  wire logic [3:0]    multi_channel_rx_on_in,
  // Mapping, control and status levels
  output logic               rom_from_internal_out,
  output logic [31:0]        rom_map_base_out,
  output logic [31:0]        node_report_base_out,
  output logic               big_endian_select_out,
  output logic               link_power_on_out,
  output logic               late_store_allow_out,
  output logic               link_on_out,
  output logic               sw_restart_out,
  output logic               late_store_fault_flag_out,
  output logic [31:0]        rx_multichannel_select_out,
  output logic [3:0]         multi_channel_grant_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pointer and count widths are sized for a four-entry log
  if (LOG_DEPTH != 4)
  begin : g_depth_check
    $error("hlcs_regs: LOG_DEPTH must be 4");
  end
  // The request port and grant chain serve exactly four contexts
  if (NUM_CTX != 4)
  begin : g_ctx_check
    $error("hlcs_regs: NUM_CTX must be 4");
  end

  typedef struct packed {
    // Restart sequencing and bus handshake
    hlcs_pkg::hlcs_mode_e mode;
    logic                 ack;
    logic [31:0]          rdata;
    // Software controlled configuration
    logic [21:0]          rom_base;
    logic [20:0]          nr_base;
    logic                 big_endian;
    logic                 link_power;
    logic                 late_allow;
    logic                 link_on;
    logic [7:0]           restart_cnt;
    // Node report status and multi-channel select
    logic                 nr_fault;
    logic [7:0]           nr_epoch;
    logic [10:0]          nr_len;
    logic [31:0]          mc_select;
    // Late store fault event and log
    logic                 fault_flag;
    logic [3:0][15:0]     log_src;
    logic [3:0][47:0]     log_off;
    logic [1:0]           wp;
    logic [1:0]           rp;
    logic [2:0]           count;
  } hlcs_state_s;

  hlcs_state_s s_q;
  hlcs_state_s s_d;

  logic        req;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] ctl_word;
  logic [31:0] rd_mux;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [3:0]  grant;
  logic [3:0]  lower_req;
  logic        do_push;
  logic        do_pop;
  logic        ev_clear;
  logic        restarting;
  logic [2:0]  count_next;

  // One wait cycle per access keeps read data registered
  assign req             = read_in | write_in;
  assign waitrequest_out = req & ~s_q.ack;
  assign wr_go           = write_in & s_q.ack;
  assign rd_go           = read_in & s_q.ack;
  assign restarting      = (s_q.mode == hlcs_pkg::HLCS_RESTART);

  // Disabled lanes write as zero, so set and clear leave them alone
  for (genvar b = 0; b < 4; b++)
  begin : g_lane
    assign wmask[b*8 +: 8] = {8{byteenable_in[b]}};
  end
  assign wval = writedata_in & wmask;

  always_comb
  begin
    ctl_word = 32'h0000_0000;
    ctl_word[hlcs_pkg::BIT_BIG_ENDIAN] = s_q.big_endian;   // [RQ11]
    ctl_word[hlcs_pkg::BIT_PHY_PROG]   = 1'b0;             // [RQ12]
    ctl_word[hlcs_pkg::BIT_ENH_PHY]    = 1'b1;             // [RQ12]
    ctl_word[hlcs_pkg::BIT_LINK_POWER] = s_q.link_power;
    ctl_word[hlcs_pkg::BIT_LATE_ALLOW] = s_q.late_allow;
    ctl_word[hlcs_pkg::BIT_LINK_ON]    = s_q.link_on;
    ctl_word[hlcs_pkg::BIT_SW_RESTART] = restarting;       // [RQ16]
  end

  // Lowest numbered requesting context owns the multi-channel select
  for (genvar c = 0; c < NUM_CTX; c++)
  begin : g_ctx
    if (c == 0)
    begin : g_first
      assign lower_req[c] = 1'b0;
    end
    else
    begin : g_rest
      assign lower_req[c] = lower_req[c-1] | multi_channel_rx_on_in[c-1];
    end
    assign grant[c] = multi_channel_rx_on_in[c] & ~lower_req[c];  // [RQ21]
  end

  // Captured in the wait cycle, so a popping read returns the entry it retires
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (address_in)
      hlcs_pkg::OFS_ROM_MAP:
        rd_mux = {s_q.rom_base, 10'h000};
      hlcs_pkg::OFS_LOG_UPPER:
        rd_mux = {s_q.log_src[s_q.rp], s_q.log_off[s_q.rp][47:32]};  // [RQ8]
      hlcs_pkg::OFS_LOG_LOWER:
        rd_mux = s_q.log_off[s_q.rp][31:0];
      hlcs_pkg::OFS_VENDOR:
        rd_mux = {VENDOR_EXTRA, ORG_CODE};                  // [RQ9]
      hlcs_pkg::OFS_CTL_SET,
      hlcs_pkg::OFS_CTL_CLR:
        rd_mux = ctl_word;
      hlcs_pkg::OFS_NR_BASE:
        rd_mux = {s_q.nr_base, 11'h000};
      hlcs_pkg::OFS_NR_COUNT:
        rd_mux = {s_q.nr_fault, 7'h00, s_q.nr_epoch, 3'h0, s_q.nr_len, 2'h0};
      hlcs_pkg::OFS_MC_SELECT:
        rd_mux = s_q.mc_select;
      hlcs_pkg::OFS_MC_GRANT:
        rd_mux = {24'h000000, grant, multi_channel_rx_on_in};
      hlcs_pkg::OFS_EVENTS:
        rd_mux = 32'(s_q.fault_flag) << hlcs_pkg::BIT_LATE_FAULT;
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  // Capture only with logging allowed and room left; overflow entries are lost
  assign do_push  = late_store_err_in & s_q.late_allow &
                    (s_q.count != 3'(LOG_DEPTH));           // [RQ4] [RQ5]
  // Reading the lower word retires the oldest entry
  assign do_pop   = rd_go & (address_in == hlcs_pkg::OFS_LOG_LOWER) &
                    (s_q.count != 3'h0);                    // [RQ6]
  assign ev_clear = wr_go & (address_in == hlcs_pkg::OFS_EVENTS) &
                    wval[hlcs_pkg::BIT_LATE_FAULT];

  always_comb
  begin
    count_next = s_q.count;
    if (do_push & ~do_pop)
      count_next = s_q.count + 3'h1;
    else if (do_pop & ~do_push)
      count_next = s_q.count - 3'h1;
  end

  always_comb
  begin
    s_d       = s_q;
    s_d.ack   = req & ~s_q.ack;
    if (req & ~s_q.ack)
      s_d.rdata = rd_mux;

    if (wr_go)
    begin
      case (address_in)
        hlcs_pkg::OFS_ROM_MAP:
          s_d.rom_base = wval[31:hlcs_pkg::ROM_ALIGN_BITS];  // [RQ1]
        hlcs_pkg::OFS_NR_BASE:
          s_d.nr_base = wval[31:hlcs_pkg::NR_ALIGN_BITS];    // [RQ20]
        hlcs_pkg::OFS_MC_SELECT:
          s_d.mc_select = wval;
        hlcs_pkg::OFS_CTL_SET:
        begin
          if (wval[hlcs_pkg::BIT_BIG_ENDIAN])
            s_d.big_endian = 1'b1;                           // [RQ11]
          if (wval[hlcs_pkg::BIT_LINK_POWER])
            s_d.link_power = 1'b1;                           // [RQ14]
          if (wval[hlcs_pkg::BIT_LATE_ALLOW])
            s_d.late_allow = 1'b1;                           // [RQ5]
          if (wval[hlcs_pkg::BIT_LINK_ON])
            s_d.link_on = 1'b1;                              // [RQ15]
        end
        hlcs_pkg::OFS_CTL_CLR:
        begin
          if (wval[hlcs_pkg::BIT_BIG_ENDIAN])
            s_d.big_endian = 1'b0;
          if (wval[hlcs_pkg::BIT_LINK_POWER])
            s_d.link_power = 1'b0;
          if (wval[hlcs_pkg::BIT_LATE_ALLOW])
            s_d.late_allow = 1'b0;
          if (wval[hlcs_pkg::BIT_LINK_ON])
            s_d.link_on = 1'b0;
        end
        default:
        begin
        end
      endcase
    end

    // A disconnect overrides any link on write in the same cycle
    if (disconnect_in)
      s_d.link_on = 1'b0;                                    // [RQ13]

    // Log store
    if (do_push)
    begin
      s_d.log_src[s_q.wp] = originator_node_in;              // [RQ4]
      s_d.log_off[s_q.wp] = fault_offset_in;
      s_d.wp              = s_q.wp + 2'h1;
    end
    if (do_pop)
      s_d.rp = s_q.rp + 2'h1;
    s_d.count = count_next;

    // Clear holds off while entries remain, so software loops; a new error wins
    if (ev_clear & (count_next == 3'h0))
      s_d.fault_flag = 1'b0;                                 // [RQ7]
    if (late_store_err_in & s_q.late_allow)
      s_d.fault_flag = 1'b1;                                 // [RQ23] [RQ4]

    // Node report status
    if (node_report_done_in)
      s_d.nr_len = node_report_length_in;
    if (bus_reset_in)
    begin
      s_d.nr_epoch = s_q.nr_epoch + 8'h01;                   // [RQ18]
      s_d.nr_len   = 11'h000;                                // [RQ19]
      s_d.nr_fault = 1'b0;
    end
    if (node_report_store_fault_in)
      s_d.nr_fault = 1'b1;                                   // [RQ17]

    case (s_q.mode)
      hlcs_pkg::HLCS_RUN:
      begin
        if (wr_go & (address_in == hlcs_pkg::OFS_CTL_SET) &
            wval[hlcs_pkg::BIT_SW_RESTART])
        begin
          s_d.mode        = hlcs_pkg::HLCS_RESTART;          // [RQ16]
          s_d.restart_cnt = hlcs_pkg::RST_RESTART_CNT;
        end
      end
      hlcs_pkg::HLCS_RESTART:
      begin
        // Soft restart drops the link and flushes the log; bases survive
        s_d.link_on    = 1'b0;
        s_d.link_power = 1'b0;
        s_d.fault_flag = 1'b0;
        s_d.wp         = 2'h0;
        s_d.rp         = 2'h0;
        s_d.count      = 3'h0;
        if (s_q.restart_cnt == 8'h00)
          s_d.mode = hlcs_pkg::HLCS_RUN;
        else
          s_d.restart_cnt = s_q.restart_cnt - 8'h01;
      end
      default:
        s_d.mode = hlcs_pkg::HLCS_RUN;
    endcase
  end

  // Reset parks in restart so software sees bit 16 until the count expires
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      s_q             <= '0;
      s_q.mode        <= hlcs_pkg::HLCS_RESTART;             // [RQ16]
      s_q.restart_cnt <= hlcs_pkg::RST_RESTART_CNT;
      s_q.link_on     <= hlcs_pkg::RST_LINK_ON;              // [RQ15]
      s_q.link_power  <= hlcs_pkg::RST_LINK_POWER;           // [RQ14]
    end
    else
      s_q <= s_d;
  end

  // Offsets under 20 bytes bypass the host memory mapping
  assign rom_from_internal_out = (rom_fetch_offset_in < hlcs_pkg::ROM_INTERNAL_BYTES); // [RQ2]

  assign readdata_out               = s_q.rdata;
  assign rom_map_base_out           = {s_q.rom_base, 10'h000};
  assign node_report_base_out       = {s_q.nr_base, 11'h000};
  assign big_endian_select_out      = s_q.big_endian;
  assign link_power_on_out          = s_q.link_power;
  assign late_store_allow_out       = s_q.late_allow;
  assign link_on_out                = s_q.link_on;
  assign sw_restart_out             = restarting;
  assign late_store_fault_flag_out  = s_q.fault_flag;
  // Select reaches the fabric only for a granted context
  assign rx_multichannel_select_out = (grant != 4'h0) ? s_q.mc_select : 32'h0000_0000; // [RQ21]
  assign multi_channel_grant_out    = grant;

endmodule

//--- hlcs_regs_asserts.sv
// Checker for hlcs_regs: bus handshake, alignment, event and control bits.
// Sees the top module's ports only; bound into every hlcs_regs instance.
module hlcs_regs_asserts #(
  parameter logic [7:0]  VENDOR_EXTRA = 8'h5a,
  parameter logic [23:0] ORG_CODE     = 24'h3c1e07
) (
  input wire logic        clock_in,
  input wire logic        nrst_in,
  input wire logic [5:0]  address_in,
  input wire logic        read_in,
  input wire logic        write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0]  byteenable_in,
  input wire logic [31:0] readdata_out,
  input wire logic        waitrequest_out,
  input wire logic        late_store_err_in,
  input wire logic        disconnect_in,
  input wire logic [9:0]  rom_fetch_offset_in,
  input wire logic [3:0]  multi_channel_rx_on_in,
  input wire logic        rom_from_internal_out,
  input wire logic [31:0] rom_map_base_out,
  input wire logic [31:0] node_report_base_out,
  input wire logic        late_store_allow_out,
  input wire logic        link_on_out,
  input wire logic        sw_restart_out,
  input wire logic        late_store_fault_flag_out,
  input wire logic [31:0] rx_multichannel_select_out,
  input wire logic [3:0]  multi_channel_grant_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_rd_done;
    read_in && !waitrequest_out;
  endsequence
  // Restart holds the flag clear, so errors then are left out
  sequence s_fault;
    late_store_err_in && late_store_allow_out && !sw_restart_out;
  endsequence
  sequence s_restart_wr;
    write_in && !waitrequest_out && address_in == hlcs_pkg::OFS_CTL_SET
      && byteenable_in[2] && writedata_in[16];
  endsequence

  a_bus_one_wait: assert property ($rose(read_in || write_in) |-> waitrequest_out ##1
    !waitrequest_out) else $error("waitrequest not one cycle");
  a_rom_align: assert property (rom_map_base_out[9:0] == 10'h000)
    else $error("rom base misaligned");
  a_rom_internal: assert property (rom_from_internal_out == (rom_fetch_offset_in < 10'h014))
    else $error("internal rom span wrong");
  a_fault_flagged: assert property (s_fault |=> late_store_fault_flag_out)
    else $error("fault flag not set");
  a_fault_ignored: assert property (late_store_err_in && !late_store_allow_out
    && !late_store_fault_flag_out |=> !late_store_fault_flag_out) else $error("flag set while off");
  a_vendor_fixed: assert property (s_rd_done ##0 address_in == hlcs_pkg::OFS_VENDOR
    |-> readdata_out == {VENDOR_EXTRA, ORG_CODE}) else $error("vendor word wrong");
  a_ctl_fixed_bits: assert property (s_rd_done ##0 address_in == hlcs_pkg::OFS_CTL_SET
    |-> readdata_out[23:22] == 2'b01) else $error("fixed control bits wrong");
  a_disconnect_off: assert property (disconnect_in |=> !link_on_out)
    else $error("link on survived disconnect");
  a_restart_start: assert property (s_restart_wr |=> sw_restart_out[*3])
    else $error("restart not started");
  a_restart_reset: assert property ($rose(nrst_in) |-> sw_restart_out)
    else $error("restart bit low after reset");
  a_nr_align: assert property (node_report_base_out[10:0] == 11'h000)
    else $error("node report base misaligned");
  a_grant_lowest: assert property (multi_channel_grant_out == (multi_channel_rx_on_in
    & (~multi_channel_rx_on_in + 4'h1))) else $error("grant not lowest requester");
  a_select_gated: assert property (multi_channel_grant_out == 4'h0 |->
    rx_multichannel_select_out == 32'h0) else $error("select shown without grant");
endmodule

bind hlcs_regs hlcs_regs_asserts #(.VENDOR_EXTRA(VENDOR_EXTRA), .ORG_CODE(ORG_CODE)) u_chk (
  .clock_in(clock_in), .nrst_in(nrst_in), .address_in(address_in), .read_in(read_in),
  .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
  .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
  .late_store_err_in(late_store_err_in), .disconnect_in(disconnect_in),
  .rom_fetch_offset_in(rom_fetch_offset_in), .multi_channel_rx_on_in(multi_channel_rx_on_in),
  .rom_from_internal_out(rom_from_internal_out), .rom_map_base_out(rom_map_base_out),
  .node_report_base_out(node_report_base_out), .late_store_allow_out(late_store_allow_out),
  .link_on_out(link_on_out), .sw_restart_out(sw_restart_out),
  .late_store_fault_flag_out(late_store_fault_flag_out),
  .rx_multichannel_select_out(rx_multichannel_select_out),
  .multi_channel_grant_out(multi_channel_grant_out));

//--- hlcs_regs_test.sv
// Self-checking bench for hlcs_regs, driving every port directly.
// Assumes one wait cycle per Avalon access and a 26-cycle soft restart.
module hlcs_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_in, nrst_in, read_in, write_in, waitrequest_out;
  logic        rom_from_internal_out, big_endian_select_out, link_power_on_out;
  logic        late_store_allow_out, link_on_out, sw_restart_out, late_store_fault_flag_out;
  logic [3:0]  byteenable_in, multi_channel_rx_on_in, multi_channel_grant_out;
  logic [4:0]  ev;
  logic [5:0]  address_in;
  logic [9:0]  rom_fetch_offset_in;
  logic [10:0] node_report_length_in;
  logic [15:0] originator_node_in;
  logic [31:0] writedata_in, readdata_out, rom_map_base_out, node_report_base_out, rd;
  logic [31:0] rx_multichannel_select_out;
  logic [47:0] fault_offset_in;
  int          failures, comparisons;

  hlcs_regs i_dut (
    .clock_in(clock_in), .nrst_in(nrst_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .late_store_err_in(ev[0]), .originator_node_in(originator_node_in),
    .fault_offset_in(fault_offset_in), .bus_reset_in(ev[1]), .disconnect_in(ev[2]),
    .node_report_store_fault_in(ev[3]), .node_report_done_in(ev[4]),
    .node_report_length_in(node_report_length_in), .rom_fetch_offset_in(rom_fetch_offset_in),
    .multi_channel_rx_on_in(multi_channel_rx_on_in), .rom_from_internal_out(rom_from_internal_out),
    .rom_map_base_out(rom_map_base_out), .node_report_base_out(node_report_base_out),
    .big_endian_select_out(big_endian_select_out), .link_power_on_out(link_power_on_out),
    .late_store_allow_out(late_store_allow_out), .link_on_out(link_on_out),
    .sw_restart_out(sw_restart_out), .late_store_fault_flag_out(late_store_fault_flag_out),
    .rx_multichannel_select_out(rx_multichannel_select_out),
    .multi_channel_grant_out(multi_channel_grant_out));

  always #20 clock_in = ~clock_in;

  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Sample at the falling edge: the value the next rising edge will see
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int   n;
    logic w;
    n = 0;
    @(posedge clock_in);
    read_in <= !wr;
    write_in <= wr;
    address_in <= a;
    writedata_in <= d;
    do
    begin
      @(negedge clock_in);
      w = waitrequest_out;
      rd = readdata_out;
      @(posedge clock_in);
      n++;
    end while (w && n < 50);
    read_in <= 1'b0;
    write_in <= 1'b0;
    if (w)
    begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic pulse(input logic [4:0] e);
    @(posedge clock_in);
    ev <= e;
    @(posedge clock_in);
    ev <= 5'h00;
    @(negedge clock_in);
  endtask

  task automatic wait_restart;
    int n;
    n = 0;
    while (sw_restart_out !== 1'b0 && n < 100)
    begin
      @(negedge clock_in);
      n++;
    end
    if (sw_restart_out !== 1'b0)
    begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic t_after_reset;
    rdchk(hlcs_pkg::OFS_CTL_SET, 32'h0041_0000);
    wait_restart();
    rdchk(hlcs_pkg::OFS_CTL_CLR, 32'h0040_0000);
    bus(1'b1, hlcs_pkg::OFS_VENDOR, 32'hffff_ffff);
    rdchk(hlcs_pkg::OFS_VENDOR, 32'h5a3c_1e07);
    bus(1'b1, 6'h2c, 32'hffff_ffff);
    rdchk(6'h2c, 32'h0);
    $display("test after_reset done");
  endtask

  task automatic t_control;
    bus(1'b1, hlcs_pkg::OFS_ROM_MAP, 32'h1234_5678);
    rdchk(hlcs_pkg::OFS_ROM_MAP, 32'h1234_5400);
    chk(rom_map_base_out, 32'h1234_5400);
    byteenable_in <= 4'h3;
    bus(1'b1, hlcs_pkg::OFS_ROM_MAP, 32'hffff_ffff);
    byteenable_in <= 4'hf;
    rdchk(hlcs_pkg::OFS_ROM_MAP, 32'h0000_fc00);
    bus(1'b1, hlcs_pkg::OFS_CTL_SET, 32'h400c_0000);
    rdchk(hlcs_pkg::OFS_CTL_SET, 32'h404c_0000);
    chk({big_endian_select_out, link_power_on_out, late_store_allow_out}, 3'b111);
    bus(1'b1, hlcs_pkg::OFS_CTL_SET, 32'h0002_0000);
    @(negedge clock_in);
    chk(link_on_out, 1'b1);
    pulse(5'h04);
    chk(link_on_out, 1'b0);
    bus(1'b1, hlcs_pkg::OFS_CTL_CLR, 32'h4000_0000);
    @(negedge clock_in);
    chk(big_endian_select_out, 1'b0);
    $display("test control done");
  endtask

  task automatic t_fault_log;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clock_in);
      originator_node_in <= 16'h0100 + 16'(i);
      fault_offset_in <= {16'ha000 + 16'(i), 32'h1000_0000 + 32'(i)};
      pulse(5'h01);
    end
    chk(late_store_fault_flag_out, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      rdchk(hlcs_pkg::OFS_LOG_UPPER, {16'h0100 + 16'(i), 16'ha000 + 16'(i)});
      rdchk(hlcs_pkg::OFS_LOG_LOWER, 32'h1000_0000 + 32'(i));
      bus(1'b1, hlcs_pkg::OFS_EVENTS, 32'h0000_0100);
      @(negedge clock_in);
      chk(late_store_fault_flag_out, 32'(i < 3));
    end
    bus(1'b1, hlcs_pkg::OFS_CTL_CLR, 32'h0004_0000);
    pulse(5'h01);
    chk({late_store_allow_out, late_store_fault_flag_out}, 2'b00);
    $display("test fault_log done");
  endtask

  task automatic t_node_report;
    @(posedge clock_in);
    node_report_length_in <= 11'h155;
    pulse(5'h10);
    rdchk(hlcs_pkg::OFS_NR_COUNT, 32'h0000_0554);
    pulse(5'h02);
    rdchk(hlcs_pkg::OFS_NR_COUNT, 32'h0001_0000);
    pulse(5'h08);
    rdchk(hlcs_pkg::OFS_NR_COUNT, 32'h8001_0000);
    bus(1'b1, hlcs_pkg::OFS_NR_BASE, 32'hffff_ffff);
    rdchk(hlcs_pkg::OFS_NR_BASE, 32'hffff_f800);
    chk(node_report_base_out, 32'hffff_f800);
    $display("test node_report done");
  endtask

  task automatic t_multi;
    logic [3:0] rq[5] = '{4'h0, 4'ha, 4'hc, 4'h8, 4'hf};
    logic [3:0] gr[5] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'h1};
    bus(1'b1, hlcs_pkg::OFS_MC_SELECT, 32'hdead_beef);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clock_in);
      multi_channel_rx_on_in <= rq[i]; // Fill and header bits taken as set
      rom_fetch_offset_in <= 10'h012 + 10'(i);
      @(negedge clock_in);
      chk(multi_channel_grant_out, gr[i]);
      chk(rx_multichannel_select_out, (i == 0) ? 32'h0 : 32'hdead_beef);
      chk(rom_from_internal_out, 32'(i < 2));
    end
    rdchk(hlcs_pkg::OFS_MC_SELECT, 32'hdead_beef);
    rdchk(hlcs_pkg::OFS_MC_GRANT, 32'h0000_001f);
    $display("test multi done");
  endtask

  task automatic t_restart;
    bus(1'b1, hlcs_pkg::OFS_CTL_SET, 32'h0008_0000);
    bus(1'b1, hlcs_pkg::OFS_CTL_SET, 32'h0001_0000);
    @(negedge clock_in);
    chk(sw_restart_out, 1'b1);
    rdchk(hlcs_pkg::OFS_CTL_SET, 32'h0041_0000);
    wait_restart();
    rdchk(hlcs_pkg::OFS_CTL_SET, 32'h0040_0000);
    $display("test restart done");
  endtask

  initial
  begin
    {clock_in, nrst_in, read_in, write_in, ev, address_in, writedata_in} = '0;
    {rom_fetch_offset_in, node_report_length_in, multi_channel_rx_on_in} = '0;
    {originator_node_in, fault_offset_in} = '0;
    byteenable_in = 4'hf;
    failures = 0;
    comparisons = 0;
    repeat (3) @(posedge clock_in);
    nrst_in <= 1'b1;
    t_after_reset();
    t_control();
    t_fault_log();
    t_node_report();
    t_multi();
    t_restart();
    wrap_up();
  end
endmodule
